// ==== msd_defines.vh ====
`ifndef MSD_DEFINES_VH
`define MSD_DEFINES_VH

// ============================================================
// Logic input bus
`define MSD_IN_W            57
`define MSD_ADDR_W          16

// ============================================================
// Decode array product terms
`define MSD_MAIN_SECTORS    8
`define MSD_SEC_SECTORS     4
`define MSD_FLASH_TERMS     3
`define MSD_SRAM_TERMS      2
`define MSD_REG_TERMS       1
`define MSD_IO_TERMS        1
`define MSD_DEC_TERMS       40
`define MSD_MAIN_BASE       0
`define MSD_SEC_BASE        24
`define MSD_SRAM_BASE       36
`define MSD_REG_BASE        38
`define MSD_IO_BASE         39

// ============================================================
// General array
`define MSD_GEN_OUTS        19
`define MSD_GEN_TERMS       95

// ============================================================
// Register block offsets
`define MSD_PAGE_OFS        8'he0
`define MSD_SPACE_MAP_OFS   8'hc2

// ============================================================
// Space map fields
`define MSD_SM_SRAM_CODE    0
`define MSD_SM_SEC_CODE     1
`define MSD_SM_MAIN_CODE    2
`define MSD_SM_SEC_DATA     3
`define MSD_SM_MAIN_DATA    4
`define MSD_SM_W            5

// ============================================================
// Reset values
`define MSD_PAGE_RST        8'h00
`define MSD_SPACE_MAP_RST   8'h0c

`endif

// ==== msd_term_array.v ====
`timescale 1ns/1ps
`include "msd_defines.vh"

// ============================================================
// AND array: each term sees every input true and complemented
module msd_term_array #(
    parameter TERMS = 1,
    parameter IN_W  = `MSD_IN_W
) (
    in_bus,
    and_mask,
    terms
);
    input  wire [IN_W-1:0]         in_bus;
    input  wire [TERMS*2*IN_W-1:0] and_mask;
    output wire [TERMS-1:0]        terms;

    wire [2*IN_W-1:0] literals;

    assign literals = {~in_bus, in_bus};

    genvar t;
    generate
        for (t = 0; t < TERMS; t = t + 1) begin : g_term
            wire [2*IN_W-1:0] m;
            assign m = and_mask[t*2*IN_W +: 2*IN_W];
            // An empty mask is an unused term, held false
            assign terms[t] = (|m) & (&(literals | ~m));
        end
    endgenerate

endmodule

// ==== msd_regs.v ====
`timescale 1ns/1ps
`include "msd_defines.vh"

// ============================================================
// Page and space map registers in the register block
module msd_regs #(
    parameter [7:0] SPACE_MAP_INIT = `MSD_SPACE_MAP_RST
) (
    clk,
    rstn,
    sel,
    wr,
    offset,
    wdata,
    page,
    space_map,
    rdata
);
    input  wire                    clk;
    input  wire                    rstn;
    input  wire                    sel;
    input  wire                    wr;
    input  wire [7:0]              offset;
    input  wire [7:0]              wdata;
    output wire [7:0]              page;
    output wire [`MSD_SM_W-1:0]    space_map;
    output reg  [7:0]              rdata;

    reg [7:0]           page_reg;
    reg [`MSD_SM_W-1:0] space_map_reg;

    always @(posedge clk) begin
        if (!rstn) begin
            page_reg      <= `MSD_PAGE_RST;
            space_map_reg <= SPACE_MAP_INIT[`MSD_SM_W-1:0];
        end else if (sel && wr) begin
            if (offset == `MSD_PAGE_OFS) begin
                page_reg <= wdata;
            end
            // Upper bits are not stored, so they always read zero
            if (offset == `MSD_SPACE_MAP_OFS) begin
                space_map_reg <= wdata[`MSD_SM_W-1:0];
            end
        end
    end

    always @* begin
        rdata = 8'h00;
        if (offset == `MSD_PAGE_OFS) begin
            rdata = page_reg;
        end else if (offset == `MSD_SPACE_MAP_OFS) begin
            rdata = {3'h0, space_map_reg};
        end
    end

    assign page      = page_reg;
    assign space_map = space_map_reg;

endmodule

// ==== msd_memory_select_decode.v ====
// Function
// - SRAM enabled only while its select, at most two terms, is high.
// - Battery-on output high when enabled, supply below battery.
// - Secondary flash sector wins over overlapping main flash sector.
// - SRAM, register block or I/O select wins over any flash select.
// - Code fetch selects program space, read strobe selects data space.
// - Space map bits 4 and 3 let reads reach main, secondary flash.
// - Space map bits 2,1,0 let code fetch reach main, secondary, SRAM.
// - Space map loads initial value at reset, rewrites apply at once.
// - Eight-bit page register, writable and readable at offset E0h.
// - All eight page bits feed the programmable logic inputs.
// - 57-signal input bus and complements feed the AND array.
// - Input bus holds address, control, reset, ports, page, busy.
// - Wide address mode uses address bits 19 to 4 as inputs.
// - Decode array forms memory, register block and I/O selects.
// - General array gives 19 user outputs to ports A, B, D.
// - Decode array: 8 and 4 sectors of 3 terms, SRAM 2, block 1.
`timescale 1ns/1ps
`include "msd_defines.vh"

module msd_memory_select_decode #(
    parameter [7:0] SPACE_MAP_INIT = `MSD_SPACE_MAP_RST
) (
    CLK,
    RSTN,
    ADDR,
    WR_N,
    RD_N,
    CODE_FETCH_STROBE_N,
    WIDE_ADDR_MODE,
    POWER_DOWN_INPUT,
    PORT_A_IN,
    PORT_B_IN,
    PORT_C_IN,
    PORT_D_IN,
    FLASH_BUSY,
    SUPPLY_BELOW_BATTERY,
    BATTERY_ON_EN,
    DATA_IN,
    MEM_RDATA,
    CFG_DECODE_AND,
    CFG_GENERAL_AND,
    CFG_GENERAL_POL,
    DATA_OUT,
    DATA_OE,
    SRAM_SELECT,
    MAIN_FLASH_SECTOR_SELECT,
    SECONDARY_FLASH_SECTOR_SELECT,
    REGISTER_BLOCK_SELECT,
    IO_SELECT,
    MEM_WRITE,
    GENERAL_OUT,
    BATTERY_ON,
    PAGE_BITS,
    SPACE_MAP
);
    localparam IN_W  = `MSD_IN_W;
    localparam DEC_T = `MSD_DEC_TERMS;
    localparam GEN_T = `MSD_GEN_TERMS;
    localparam GEN_O = `MSD_GEN_OUTS;
    localparam NMAIN = `MSD_MAIN_SECTORS;
    localparam NSEC  = `MSD_SEC_SECTORS;
    localparam FT    = `MSD_FLASH_TERMS;

    input  wire                      CLK;
    input  wire                      RSTN;
    input  wire [19:0]               ADDR;
    input  wire                      WR_N;
    input  wire                      RD_N;
    input  wire                      CODE_FETCH_STROBE_N;
    input  wire                      WIDE_ADDR_MODE;
    input  wire                      POWER_DOWN_INPUT;
    input  wire [7:0]                PORT_A_IN;
    input  wire [7:0]                PORT_B_IN;
    input  wire [7:0]                PORT_C_IN;
    input  wire [2:0]                PORT_D_IN;
    input  wire                      FLASH_BUSY;
    input  wire                      SUPPLY_BELOW_BATTERY;
    input  wire                      BATTERY_ON_EN;
    input  wire [7:0]                DATA_IN;
    input  wire [7:0]                MEM_RDATA;
    input  wire [DEC_T*2*IN_W-1:0]   CFG_DECODE_AND;
    input  wire [GEN_T*2*IN_W-1:0]   CFG_GENERAL_AND;
    input  wire [GEN_O-1:0]          CFG_GENERAL_POL;
    output wire [7:0]                DATA_OUT;
    output wire                      DATA_OE;
    output wire                      SRAM_SELECT;
    output wire [NMAIN-1:0]          MAIN_FLASH_SECTOR_SELECT;
    output wire [NSEC-1:0]           SECONDARY_FLASH_SECTOR_SELECT;
    output wire                      REGISTER_BLOCK_SELECT;
    output wire                      IO_SELECT;
    output wire                      MEM_WRITE;
    output wire [GEN_O-1:0]          GENERAL_OUT;
    output wire                      BATTERY_ON;
    output wire [7:0]                PAGE_BITS;
    output wire [`MSD_SM_W-1:0]      SPACE_MAP;

    // ============================================================
    // General array output sizes: PA0-3, PA4-7, PB0-3, PB4-7, PD0-2
    function integer gen_terms;
        input integer k;
        begin
            if (k < 4) begin
                gen_terms = 3;
            end else if (k < 8) begin
                gen_terms = 9;
            end else if (k < 12) begin
                gen_terms = 4;
            end else if (k < 16) begin
                gen_terms = 7;
            end else begin
                gen_terms = 1;
            end
        end
    endfunction

    function integer gen_base;
        input integer k;
        integer j;
        begin
            gen_base = 0;
            for (j = 0; j < k; j = j + 1) begin
                gen_base = gen_base + gen_terms(j);
            end
        end
    endfunction

    // ============================================================
    // Strobes, active high inside
    wire code_fetch;
    wire data_read;
    wire data_write;
    wire any_read;

    assign code_fetch = ~CODE_FETCH_STROBE_N;
    assign data_read  = ~RD_N;
    assign data_write = ~WR_N;
    assign any_read   = code_fetch | data_read;

    // ============================================================
    // Logic input bus
    wire [`MSD_ADDR_W-1:0] addr_in;
    wire [IN_W-1:0]        in_bus;
    wire [7:0]             page_bits;

    // Wide mode drops the low nibble, which the data bus carries
    assign addr_in = WIDE_ADDR_MODE ? ADDR[19:4] : ADDR[15:0];

    // Control lines enter at pin level so either polarity is usable
    assign in_bus = {addr_in,
                     CODE_FETCH_STROBE_N, RD_N, WR_N,
                     ~RSTN,
                     POWER_DOWN_INPUT,
                     PORT_A_IN,
                     PORT_B_IN,
                     PORT_C_IN,
                     PORT_D_IN,
                     page_bits,
                     FLASH_BUSY};

    // ============================================================
    // Decode array
    wire [DEC_T-1:0] dec_terms;

    msd_term_array #(
        .TERMS (DEC_T),
        .IN_W  (IN_W)
    ) u_decode_logic_array (
        .in_bus   (in_bus),
        .and_mask (CFG_DECODE_AND),
        .terms    (dec_terms)
    );

    wire [NMAIN-1:0] main_raw;
    wire [NSEC-1:0]  sec_raw;
    wire             sram_raw;
    wire             reg_raw;
    wire             io_raw;

    genvar i;
    generate
        for (i = 0; i < NMAIN; i = i + 1) begin : g_main
            assign main_raw[i] =
                |dec_terms[`MSD_MAIN_BASE + i*FT +: FT];
        end
        for (i = 0; i < NSEC; i = i + 1) begin : g_sec
            assign sec_raw[i] =
                |dec_terms[`MSD_SEC_BASE + i*FT +: FT];
        end
    endgenerate

    assign sram_raw =
        |dec_terms[`MSD_SRAM_BASE +: `MSD_SRAM_TERMS];
    assign reg_raw  =
        |dec_terms[`MSD_REG_BASE +: `MSD_REG_TERMS];
    assign io_raw   =
        |dec_terms[`MSD_IO_BASE +: `MSD_IO_TERMS];

    // ============================================================
    // Space map gating
    wire [`MSD_SM_W-1:0] space_map;
    wire                 main_ok;
    wire                 sec_ok;
    wire                 sram_ok;
    wire                 data_ok;

    // Writes are not steered by the space map
    assign main_ok = (code_fetch & space_map[`MSD_SM_MAIN_CODE])
                   | (data_read  & space_map[`MSD_SM_MAIN_DATA])
                   | data_write;
    assign sec_ok  = (code_fetch & space_map[`MSD_SM_SEC_CODE])
                   | (data_read  & space_map[`MSD_SM_SEC_DATA])
                   | data_write;
    assign sram_ok = (code_fetch & space_map[`MSD_SM_SRAM_CODE])
                   | data_read
                   | data_write;
    // Registers and I/O live in data space only
    assign data_ok = data_read | data_write;

    // ============================================================
    // Priority resolution
    // Priority looks at raw selects: a blocked SRAM still hides flash
    wire high_raw;
    wire sec_any_raw;

    assign high_raw    = sram_raw | reg_raw | io_raw;
    assign sec_any_raw = |sec_raw;

    wire             sram_sel;
    wire             reg_sel;
    wire             io_sel;
    wire [NSEC-1:0]  sec_sel;
    wire [NMAIN-1:0] main_sel;

    assign sram_sel = sram_raw & sram_ok;
    assign reg_sel  = reg_raw & data_ok;
    assign io_sel   = io_raw & data_ok;
    assign sec_sel  = sec_raw & {NSEC{sec_ok & ~high_raw}};
    assign main_sel = main_raw
                    & {NMAIN{main_ok & ~high_raw & ~sec_any_raw}};

    wire mem_sel;
    wire any_sel;

    assign mem_sel = sram_sel | io_sel | (|sec_sel) | (|main_sel);
    assign any_sel = mem_sel | reg_sel;

    assign SRAM_SELECT                   = sram_sel;
    assign MAIN_FLASH_SECTOR_SELECT      = main_sel;
    assign SECONDARY_FLASH_SECTOR_SELECT = sec_sel;
    assign REGISTER_BLOCK_SELECT         = reg_sel;
    assign IO_SELECT                     = io_sel;
    assign MEM_WRITE                     = data_write & mem_sel;

    // ============================================================
    // Register block
    wire [7:0] reg_rdata;

    msd_regs #(
        .SPACE_MAP_INIT (SPACE_MAP_INIT)
    ) u_regs (
        .clk       (CLK),
        .rstn      (RSTN),
        .sel       (reg_sel),
        .wr        (data_write),
        .offset    (ADDR[7:0]),
        .wdata     (DATA_IN),
        .page      (page_bits),
        .space_map (space_map),
        .rdata     (reg_rdata)
    );

    assign PAGE_BITS = page_bits;
    assign SPACE_MAP = space_map;

    // ============================================================
    // Read data path
    // One cycle of latency buys a clean flip-flop output on the bus
    reg [7:0] data_out_reg;
    reg [7:0] data_out_next;
    reg       data_oe_reg;
    reg       data_oe_next;

    always @* begin
        data_out_next = data_out_reg;
        data_oe_next  = 1'b0;
        if (any_read && any_sel) begin
            data_oe_next  = 1'b1;
            data_out_next = reg_sel ? reg_rdata : MEM_RDATA;
        end
    end

    always @(posedge CLK) begin
        if (!RSTN) begin
            data_out_reg <= 8'h00;
            data_oe_reg  <= 1'b0;
        end else begin
            data_out_reg <= data_out_next;
            data_oe_reg  <= data_oe_next;
        end
    end

    assign DATA_OUT = data_out_reg;
    assign DATA_OE  = data_oe_reg;

    // ============================================================
    // General array
    wire [GEN_T-1:0] gen_terms_w;

    msd_term_array #(
        .TERMS (GEN_T),
        .IN_W  (IN_W)
    ) u_general_logic_array (
        .in_bus   (in_bus),
        .and_mask (CFG_GENERAL_AND),
        .terms    (gen_terms_w)
    );

    generate
        for (i = 0; i < GEN_O; i = i + 1) begin : g_gen
            localparam integer B = gen_base(i);
            localparam integer N = gen_terms(i);
            assign GENERAL_OUT[i] =
                (|gen_terms_w[B +: N]) ^ CFG_GENERAL_POL[i];
        end
    endgenerate

    // ============================================================
    // Battery indicator
    reg battery_on_reg;

    always @(posedge CLK) begin
        if (!RSTN) begin
            battery_on_reg <= 1'b0;
        end else begin
            battery_on_reg <= BATTERY_ON_EN & SUPPLY_BELOW_BATTERY;
        end
    end

    assign BATTERY_ON = battery_on_reg;

endmodule

// ==== msd_props.sv ====
`timescale 1ns/1ps
// ============================================================
// Port checker for the memory select decode block
module msd_props #(
    parameter [7:0] SPACE_MAP_INIT = 8'h0c
) (
    input logic        CLK,
    input logic        RSTN,
    input logic [19:0] ADDR,
    input logic        WR_N,
    input logic        RD_N,
    input logic        CODE_FETCH_STROBE_N,
    input logic [7:0]  DATA_IN,
    input logic        SUPPLY_BELOW_BATTERY,
    input logic        BATTERY_ON_EN,
    input logic [7:0]  DATA_OUT,
    input logic        DATA_OE,
    input logic        SRAM_SELECT,
    input logic [7:0]  MAIN_FLASH_SECTOR_SELECT,
    input logic [3:0]  SECONDARY_FLASH_SECTOR_SELECT,
    input logic        REGISTER_BLOCK_SELECT,
    input logic        IO_SELECT,
    input logic        BATTERY_ON,
    input logic [7:0]  PAGE_BITS,
    input logic [4:0]  SPACE_MAP
);
    wire rd  = !RD_N && WR_N && CODE_FETCH_STROBE_N;
    wire fe  = !CODE_FETCH_STROBE_N && WR_N && RD_N;
    wire hit = REGISTER_BLOCK_SELECT && ADDR[7:0] == 8'he0;
    wire hi  = SRAM_SELECT || REGISTER_BLOCK_SELECT || IO_SELECT;
    wire mf  = |MAIN_FLASH_SECTOR_SELECT;
    wire sf  = |SECONDARY_FLASH_SECTOR_SELECT;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // ============================================================
    // Priority and space gating
    a_sec_over_main:
        assert property (sf |-> !mf)
        else $error("main flash selected beside secondary flash");
    a_sram_over_flash:
        assert property (hi |-> !mf && !sf)
        else $error("flash selected beside sram or register block");
    a_read_gate:
        assert property (rd |-> (!mf || SPACE_MAP[4]) && (!sf || SPACE_MAP[3]))
        else $error("data read reached a blocked flash");
    a_fetch_gate:
        assert property (fe |-> (!mf || SPACE_MAP[2]) && (!sf || SPACE_MAP[1])
                         && (!SRAM_SELECT || SPACE_MAP[0]))
        else $error("code fetch reached a blocked memory");

    // ============================================================
    // Registers and data bus
    a_reset_values:
        assert property ($rose(RSTN) |->
            PAGE_BITS == 8'h00 && SPACE_MAP == SPACE_MAP_INIT[4:0])
        else $error("register reset value wrong");
    a_page_write:
        assert property (!WR_N && hit |=> PAGE_BITS == $past(DATA_IN))
        else $error("page write not taken");
    a_page_read:
        assert property (rd && hit |=>
            DATA_OE && DATA_OUT == $past(PAGE_BITS))
        else $error("page read data wrong");
    a_idle_bus:
        assert property (RD_N && CODE_FETCH_STROBE_N |=> !DATA_OE)
        else $error("data bus driven without a read");
    a_no_select:
        assert property ((rd || fe) && !hi && !mf && !sf |=> !DATA_OE)
        else $error("data bus driven with no select");
    a_battery_flag:
        assert property (BATTERY_ON_EN && SUPPLY_BELOW_BATTERY |=> BATTERY_ON)
        else $error("battery indicator not raised");

    c_page_read: cover property (rd && hit);
    c_fetch_main: cover property (fe && mf);
    c_read_sec: cover property (rd && sf);
    c_io_read: cover property (rd && IO_SELECT);
endmodule

bind msd_memory_select_decode msd_props #(
    .SPACE_MAP_INIT(SPACE_MAP_INIT)
) u_props (
    .CLK, .RSTN, .ADDR, .WR_N, .RD_N, .CODE_FETCH_STROBE_N, .DATA_IN,
    .SUPPLY_BELOW_BATTERY, .BATTERY_ON_EN, .DATA_OUT, .DATA_OE,
    .SRAM_SELECT, .MAIN_FLASH_SECTOR_SELECT, .SECONDARY_FLASH_SECTOR_SELECT,
    .REGISTER_BLOCK_SELECT, .IO_SELECT, .BATTERY_ON, .PAGE_BITS, .SPACE_MAP
);

// ==== msd_mcu_model.sv ====
`timescale 1ns/1ps
// ============================================================
// Bus master: one strobe per cycle, moved only on falling edges
module msd_mcu_model (
    input  wire         clk,
    output logic [19:0] addr,
    output logic        wr_n,
    output logic        rd_n,
    output logic        fetch_n,
    output logic [7:0]  wdata
);
    initial begin
        addr = 20'h00000;
        wr_n = 1'b1;
        rd_n = 1'b1;
        fetch_n = 1'b1;
        wdata = 8'h00;
    end

    // Kind 0 write, 1 data read, 2 code fetch
    task automatic start(input int k, input logic [19:0] a,
                         input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        if (k == 0 && a[7:0] == 8'hc2)
            wdata[7:5] = 3'h0;
        wr_n = k != 0;
        rd_n = k != 1;
        fetch_n = k != 2;
    endtask

    task automatic finish();
        @(negedge clk);
        wr_n = 1'b1;
        rd_n = 1'b1;
        fetch_n = 1'b1;
        // Released data shows its inverse so stale bytes never match
        wdata = ~wdata;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic           CLK = 1'b0;
    logic           RSTN = 1'b0;
    wire  [19:0]    ADDR;
    wire            WR_N, RD_N, CODE_FETCH_STROBE_N;
    wire  [7:0]     DATA_IN, DATA_OUT, PAGE_BITS, MAIN_FLASH_SECTOR_SELECT;
    wire  [3:0]     SECONDARY_FLASH_SECTOR_SELECT;
    wire  [4:0]     SPACE_MAP;
    wire            DATA_OE, SRAM_SELECT, REGISTER_BLOCK_SELECT, IO_SELECT;
    wire            MEM_WRITE, BATTERY_ON;
    wire  [18:0]    GENERAL_OUT;
    logic           WIDE_ADDR_MODE = 1'b0, POWER_DOWN_INPUT = 1'b0;
    logic           FLASH_BUSY = 1'b0, SUPPLY_BELOW_BATTERY = 1'b0;
    logic           BATTERY_ON_EN = 1'b0;
    logic [7:0]     PORT_A_IN = 8'h00, PORT_B_IN = 8'h00, PORT_C_IN = 8'h00;
    logic [7:0]     MEM_RDATA = 8'h00;
    logic [2:0]     PORT_D_IN = 3'h0;
    logic [4559:0]  CFG_DECODE_AND = '0;
    logic [10829:0] CFG_GENERAL_AND = '0;
    logic [18:0]    CFG_GENERAL_POL = 19'h00000;
    logic [31:0]    seed = 32'hccf1;
    int             n_errors = 0;
    int             comparisons = 0;

    always #50 CLK = ~CLK;

    msd_mcu_model mcu (.clk(CLK), .addr(ADDR), .wr_n(WR_N), .rd_n(RD_N),
        .fetch_n(CODE_FETCH_STROBE_N), .wdata(DATA_IN));

    msd_memory_select_decode DUT (.CLK, .RSTN, .ADDR, .WR_N, .RD_N,
        .CODE_FETCH_STROBE_N, .WIDE_ADDR_MODE, .POWER_DOWN_INPUT, .PORT_A_IN,
        .PORT_B_IN, .PORT_C_IN, .PORT_D_IN, .FLASH_BUSY,
        .SUPPLY_BELOW_BATTERY, .BATTERY_ON_EN, .DATA_IN, .MEM_RDATA,
        .CFG_DECODE_AND, .CFG_GENERAL_AND, .CFG_GENERAL_POL, .DATA_OUT,
        .DATA_OE, .SRAM_SELECT, .MAIN_FLASH_SECTOR_SELECT,
        .SECONDARY_FLASH_SECTOR_SELECT, .REGISTER_BLOCK_SELECT, .IO_SELECT,
        .MEM_WRITE, .GENERAL_OUT, .BATTERY_ON, .PAGE_BITS, .SPACE_MAP);

    // ============================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [113:0] term(input logic [15:0] v, c,
                                          input logic [56:0] x);
        return {{~v & c, 41'h0}, {v & c, 41'h0} | x};
    endfunction

    // Priority follows the ungated selects, gating follows the strobe
    function automatic logic [13:0] exp_sel(input logic [15:0] a,
        input int k, input logic [4:0] sm, input logic [7:0] pg);
        logic       sr, rb, s0, hide, gm, gs, gr;
        logic [7:0] m;
        sr = a[15:11] == 5'h10;
        rb = a[15:8] == 8'h40;
        s0 = a[15:13] == 3'h4;
        m = {5'h0, a[15:14] == 2'h0 && pg[0], a[15:14] == 2'h3,
             a[15:14] == 2'h2};
        // The I/O window sits over flash, so it hides flash too
        hide = sr | rb | a[15:8] == 8'h88;
        gm = k == 1 ? sm[4] : sm[2];
        gs = k == 1 ? sm[3] : sm[1];
        gr = k == 1 ? 1'b1 : sm[0];
        return {rb & k == 1, sr & gr, m & {8{gm & !hide & !s0}},
                {3'h0, s0 & gs & !hide}};
    endfunction

    task automatic cmp(input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk8(input logic [7:0] g, e);
        cmp({24'h0, g}, {24'h0, e});
    endtask

    task automatic chk_sel(input logic [13:0] g, e);
        cmp({18'h0, g}, {18'h0, e});
    endtask

    task automatic wr_reg(input logic [7:0] ofs, d);
        mcu.start(0, {12'h040, ofs}, d);
        mcu.finish();
    endtask

    task automatic rd_reg(input logic [7:0] ofs, e);
        mcu.start(1, {12'h040, ofs}, 8'h00);
        mcu.finish();
        chk8({7'h0, DATA_OE}, 8'h01);
        chk8(DATA_OUT, e);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #1000000;
        n_errors++;
        print_verdict();
    end

    // ============================================================
    // Main sequence
    initial begin
        int          i, k;
        logic [31:0] r;
        logic [15:0] a;
        logic [13:0] e;
        logic [7:0]  v, pg;
        logic [4:0]  sm;
        logic        io;
        // Sectors kept apart; secondary and sram overlap main on purpose
        CFG_DECODE_AND[0 +: 114] = term(16'h8000, 16'hc000, 57'h0);
        CFG_DECODE_AND[342 +: 114] = term(16'hc000, 16'hc000, 57'h0);
        CFG_DECODE_AND[684 +: 114] = term(16'h0000, 16'hc000, 57'h2);
        CFG_DECODE_AND[2736 +: 114] = term(16'h8000, 16'he000, 57'h0);
        CFG_DECODE_AND[4104 +: 114] = term(16'h8000, 16'hf800, 57'h0);
        CFG_DECODE_AND[4332 +: 114] = term(16'h4000, 16'hff00, 57'h0);
        CFG_DECODE_AND[4446 +: 114] = term(16'h8800, 16'hff00, 57'h0);
        repeat (12) @(negedge CLK);
        RSTN = 1'b1;
        chk8(PAGE_BITS, 8'h00);
        rd_reg(8'hc2, 8'h0c);
        $display("test reset values done");

        r = rnd();
        wr_reg(8'he0, r[7:0]);
        chk8(PAGE_BITS, r[7:0]);
        rd_reg(8'he0, r[7:0]);
        wr_reg(8'h10, ~r[7:0]);
        rd_reg(8'he0, r[7:0]);
        $display("test page register done");

        for (i = 0; i < 240; i++) begin
            r = rnd();
            if (i % 8 == 0) begin
                WIDE_ADDR_MODE = 1'b0;
                v = i == 0 ? 8'h0c : i == 8 ? 8'h14 : r[15:8];
                wr_reg(8'hc2, v);
                rd_reg(8'hc2, {3'h0, v[4:0]});
                wr_reg(8'he0, r[23:16]);
                sm = v[4:0];
                pg = r[23:16];
                r = rnd();
            end
            a = r[15:0];
            if (i % 8 == 4)
                a[15:8] = 8'h88;
            if (a[15:8] == 8'h40)
                a[8] = 1'b1;
            k = r[16] ? 1 : 2;
            WIDE_ADDR_MODE = r[17];
            MEM_RDATA = r[31:24];
            PORT_A_IN = r[27:20];
            PORT_B_IN = r[7:0];
            PORT_C_IN = r[15:8];
            PORT_D_IN = r[2:0];
            POWER_DOWN_INPUT = r[18];
            FLASH_BUSY = r[19];
            CFG_GENERAL_POL = r[18:0];
            mcu.start(k, r[17] ? {a, r[23:20]} : {r[23:20], a}, r[7:0]);
            #20;
            e = exp_sel(a, k, sm, pg);
            io = a[15:8] == 8'h88 && k == 1;
            chk8({7'h0, IO_SELECT}, {7'h0, io});
            chk_sel({REGISTER_BLOCK_SELECT, SRAM_SELECT,
                     MAIN_FLASH_SECTOR_SELECT,
                     SECONDARY_FLASH_SECTOR_SELECT}, e);
            cmp({13'h0, GENERAL_OUT}, {13'h0, CFG_GENERAL_POL});
            mcu.finish();
            chk8({7'h0, DATA_OE}, {7'h0, |e || io});
            if (|e || io)
                chk8(DATA_OUT, r[31:24]);
        end
        WIDE_ADDR_MODE = 1'b0;
        $display("test random decode done");

        // Writes pass to memory whatever the space map holds
        mcu.start(0, 20'h08000, 8'h3c);
        #20;
        chk8({6'h0, MEM_WRITE, SRAM_SELECT}, 8'h03);
        mcu.finish();
        mcu.start(0, 20'h06000, 8'h3c);
        #20;
        chk8({6'h0, MEM_WRITE, SRAM_SELECT}, 8'h00);
        mcu.finish();
        chk8({7'h0, DATA_OE}, 8'h00);
        $display("test memory write done");

        for (i = 0; i < 4; i++) begin
            {BATTERY_ON_EN, SUPPLY_BELOW_BATTERY} = i[1:0];
            @(negedge CLK);
            @(negedge CLK);
            chk8({7'h0, BATTERY_ON}, {7'h0, i == 3});
        end
        $display("test battery flag done");

        wr_reg(8'he0, 8'ha5);
        wr_reg(8'hc2, 8'h1f);
        RSTN = 1'b0;
        repeat (2) @(negedge CLK);
        RSTN = 1'b1;
        chk8(PAGE_BITS, 8'h00);
        chk8({3'h0, SPACE_MAP}, 8'h0c);
        $display("test second reset done");
        print_verdict();
    end
endmodule
